// [logic/sfm_params.svh]
// Purpose: shared constants of the synchronous flash model and its controller
// Assumes: one 250 MHz clock, synchronous active-low reset
// Notes: offsets, mode fields, reset values and timing counts
`ifndef SFM_PARAMS_SVH
`define SFM_PARAMS_SVH
`define SFM_MODE_RST   8'h6a
`define SFM_F_BL       1:0
`define SFM_F_BT       2
`define SFM_F_CL       5:3
`define SFM_F_RL       6
`define SFM_F_ID       7
`define SFM_BL4        2'h2
`define SFM_BL8        2'h3
`define SFM_CL_MIN     3'h2
`define SFM_CL_MAX     3'h6
`define SFM_CLK_MHZ    250
`define SFM_PROG_US    100
`define SFM_ERASE_US   2500000
`define SFM_CTM_US     5
`define SFM_PROG_CYC   (`SFM_PROG_US * `SFM_CLK_MHZ)
`define SFM_ERASE_CYC  (`SFM_ERASE_US * `SFM_CLK_MHZ)
`define SFM_CTM_CYC    (`SFM_CTM_US * `SFM_CLK_MHZ)
`define SFM_MRS_WAIT   11'h003
`define SFM_CTM_EXIT   13'h0805
`define SFM_CTM_MASK   13'h1c07
`define SFM_ERASED     32'hffffffff
`define SFM_ERASE_CODE 8'h30
`define SFM_R_CTRL     8'h00
`define SFM_R_ADDR     8'h04
`define SFM_R_DATA     8'h08
`define SFM_R_STAT     8'h0c
`define SFM_R_MODE     8'h10
`define SFM_R_BUF      8'h20
`endif

// [logic/sfm_pkg.sv]
// Purpose: types shared by both ends
// Assumes: sfm_params.svh
// Notes: mode merge used by both ends
`include "sfm_params.svh"
package sfm_pkg;
    typedef enum logic [2:0] {
        OP_NONE = 3'h0, OP_MODE = 3'h1, OP_READ = 3'h2, OP_PROG = 3'h3,
        OP_ERASE = 3'h4, OP_CTM_IN = 3'h5, OP_CTM_OUT = 3'h6
    } sfm_op_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0, ST_ACT = 3'h1, ST_GAP = 3'h3, ST_CMD = 3'h2, ST_WAIT = 3'h6
    } sfm_st_t;
    typedef struct packed {
        logic [2:0]  step;
        logic        prog;
        logic        prog_go;
        logic        erase_go;
        logic        ctm_go;
        logic [12:0] row;
        logic [7:0]  col;
        logic [31:0] data;
    } sfm_seq_t;
    typedef struct packed {
        logic [63:0][31:0] mem;
        logic [7:0]        mode;
        logic [12:0]       row;
        logic              row_ok, pend, act, dqm1, dqm2, busy_p, busy_e, ctm, doe_n;
        logic [2:0]        pcnt, bidx, esec;
        logic [7:0]        pcol, bcol;
        logic [29:0]       tcnt;
        logic [5:0]        ptgt;
        logic [31:0]       pdata, dout;
    } sfm_dev_t;
    typedef struct packed {
        sfm_st_t          st;
        sfm_op_t          op;
        logic [2:0]       step, ridx;
        logic [31:0]      addr, data, rdata, dq;
        logic [10:0]      cnt;
        logic [7:0]       mode;
        logic [7:0][31:0] rbuf;
        logic             ctm, cs_n, ras_n, cas_n, we_n, mr_n, dqm, dq_oe_n;
        logic [12:0]      ba;
    } sfm_ctl_t;
    // keeps reserved latency and length codes out of the mode
    function automatic logic [7:0] mode_merge(input logic [7:0] o, input logic [7:0] w);
        logic [7:0] m;
        m = w;
        if (w[`SFM_F_CL] < `SFM_CL_MIN || w[`SFM_F_CL] > `SFM_CL_MAX) m[`SFM_F_CL] = o[`SFM_F_CL];
        if (w[`SFM_F_BL] != `SFM_BL4 && w[`SFM_F_BL] != `SFM_BL8) m[`SFM_F_BL] = o[`SFM_F_BL];
        return m;
    endfunction
endpackage

// [logic/sfm_if.sv]
// Purpose: bus between memory controller and synchronous flash
// Assumes: dq resolved here from both output enables
// Notes: undriven dq reads high
`timescale 1ns/1ps
`default_nettype none
interface sfm_if;
    logic        cke, cs_n, ras_n, cas_n, we_n, mode_register_strobe_n, dqm, word, vpp;
    logic [12:0] a;
    logic [31:0] c_dq, c_dq_oe_n, d_dq, d_dq_oe_n, dq;
    assign dq = (~d_dq_oe_n & d_dq) | (d_dq_oe_n & ~c_dq_oe_n & c_dq)
              | (d_dq_oe_n & c_dq_oe_n);
    modport dev (input cke, cs_n, ras_n, cas_n, we_n, mode_register_strobe_n, dqm, word, vpp,
                 a, dq, output d_dq, d_dq_oe_n);
    modport ctl (output cke, cs_n, ras_n, cas_n, we_n, mode_register_strobe_n, dqm, word, vpp,
                 a, c_dq, c_dq_oe_n, input dq, d_dq_oe_n);
endinterface
`default_nettype wire

// [logic/sfm_seq.sv]
// Purpose: recognises program, erase and test-entry load sequences
// Assumes: ld only when the device accepts commands
// Notes: go pulses are registered, one cycle
`timescale 1ns/1ps
`default_nettype none
`include "sfm_params.svh"
module sfm_seq (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        ld,
    input  wire logic [12:0] row,
    input  wire logic [7:0]  col,
    input  wire logic [31:0] data,
    output logic             prog_go,
    output logic             erase_go,
    output logic             ctm_go,
    output logic [12:0]      go_row,
    output logic [7:0]       go_col,
    output logic [31:0]      go_data
);
    sfm_pkg::sfm_seq_t q, n;
    function automatic logic hit(input logic [7:0] r, input logic [7:0] c, input logic [7:0] d);
        return row == {5'h00, r} && col == c && data[7:0] == d;
    endfunction
    always_comb begin
        n = q;
        n.prog_go = 1'b0;
        n.erase_go = 1'b0;
        n.ctm_go = 1'b0;
        if (ld) begin
            n.step = 3'h0;
            n.row = row;
            n.col = col;
            n.data = data;
            unique case (q.step)
                3'h0: if (hit(8'haa, 8'h55, 8'haa)) n.step = 3'h1;
                3'h1: if (hit(8'h55, 8'h2a, 8'h55)) n.step = 3'h2;
                3'h2: begin
                    n.prog = hit(8'haa, 8'h55, 8'ha0);
                    if (n.prog || hit(8'haa, 8'h55, 8'h80)) n.step = 3'h3;
                end
                3'h3: begin
                    if (q.prog) n.prog_go = 1'b1;
                    else if (hit(8'haa, 8'h55, 8'haa)) n.step = 3'h4;
                end
                3'h4: begin
                    if (hit(8'h55, 8'h2a, 8'h55)) n.step = 3'h5;
                    n.ctm_go = hit(8'haa, 8'h55, 8'h70);
                end
                3'h5: n.erase_go = data[7:0] == `SFM_ERASE_CODE;
                default: n.step = 3'h0;
            endcase
        end
    end
    always_ff @(posedge clk) begin
        if (!resetn) q <= '0;
        else q <= n;
    end
    assign prog_go = q.prog_go;
    assign erase_go = q.erase_go;
    assign ctm_go = q.ctm_go;
    assign go_row = q.row;
    assign go_col = q.col;
    assign go_data = q.data;
endmodule // sfm_seq
`default_nettype wire

// [logic/sfm_dev.sv]
// Purpose: synchronous flash end: mode, burst read, program, erase, test mode
// Assumes: small array window, eight words per sector
// Notes: test-mode pin follow is combinational
`timescale 1ns/1ps
`default_nettype none
`include "sfm_params.svh"
module sfm_dev #(
    parameter int unsigned    PROG_CYC  = `SFM_PROG_CYC,
    parameter int unsigned    ERASE_CYC = `SFM_ERASE_CYC,
    parameter logic [31:0]    MFR_ID    = 32'h0000_00c3,
    parameter logic [31:0]    DEV_ID    = 32'h0000_0071
) (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic vcc_low,
    sfm_if.dev        bus
);
    // id values above are arbitrary
    sfm_pkg::sfm_dev_t q, n;
    logic        busy, cmd_on, c_mode, c_act, c_read, c_load, fire;
    logic        prog_go, erase_go, ctm_go;
    logic [12:0] go_row;
    logic [7:0]  go_col;
    logic [31:0] go_data, pin_map;
    logic [2:0]  last;
    logic [5:0]  ix;
    assign busy = q.busy_p || q.busy_e;
    assign cmd_on = bus.cke && !bus.cs_n && !q.ctm;
    assign c_mode = cmd_on && !bus.ras_n && !bus.cas_n && !bus.mode_register_strobe_n;
    assign c_act = cmd_on && !bus.ras_n && bus.cas_n && bus.mode_register_strobe_n;
    assign c_read = cmd_on && bus.ras_n && !bus.cas_n && bus.mode_register_strobe_n
                  && bus.we_n && q.row_ok;
    assign c_load = cmd_on && bus.ras_n && !bus.cas_n && bus.mode_register_strobe_n
                  && !bus.we_n && q.row_ok && !busy;
    assign fire = q.pend && q.pcnt == 3'h0;
    assign last = q.mode[`SFM_F_BL] == `SFM_BL8 ? 3'h7 : 3'h3;
    assign ix = {go_row[12:10], go_col[2:0]};

    sfm_seq u_seq (
        .clk      (clk),
        .resetn   (resetn),
        .ld       (c_load),
        .row      (q.row),
        .col      (bus.a[7:0]),
        .data     (bus.dq),
        .prog_go  (prog_go),
        .erase_go (erase_go),
        .ctm_go   (ctm_go),
        .go_row   (go_row),
        .go_col   (go_col),
        .go_data  (go_data)
    );

    function automatic logic [7:0] burst_col(input logic [7:0] s, input logic [2:0] i,
                                             input logic bl8, input logic il);
        logic [2:0] o;
        o = il ? (s[2:0] ^ i) : (s[2:0] + i);
        return bl8 ? {s[7:3], o} : {s[7:2], o[1:0]};
    endfunction

    function automatic logic [31:0] rd_word(input sfm_pkg::sfm_dev_t s, input logic [7:0] c);
        logic [5:0] k;
        k = {s.row[12:10], c[2:0]};
        if (s.mode[`SFM_F_ID]) return c[0] ? DEV_ID : MFR_ID;
        if (s.busy_e) return 32'h0000_0000;
        if (s.busy_p && k == s.ptgt) return {s.mem[k][31:8], ~s.pdata[7], s.mem[k][6:0]};
        return s.mem[k];
    endfunction

    always_comb begin
        n = q;
        if (bus.cke) begin
            n.dqm1 = bus.dqm;
            n.dqm2 = q.dqm1;
            if (c_mode && !busy) n.mode = sfm_pkg::mode_merge(q.mode, bus.a[7:0]);
            if (c_act) begin
                n.row = bus.a;
                n.row_ok = 1'b1;
            end
            // burst output stage
            n.doe_n = 1'b1;
            if (fire) begin
                n.dout = rd_word(q, burst_col(q.pcol, 3'h0, last[2], q.mode[`SFM_F_BT]));
                n.doe_n = q.dqm2;
                n.act = 1'b1;
                n.bidx = 3'h1;
                n.bcol = q.pcol;
                n.pend = 1'b0;
            end else if (q.act) begin
                n.dout = rd_word(q, burst_col(q.bcol, q.bidx, last[2], q.mode[`SFM_F_BT]));
                n.doe_n = q.dqm2;
                n.bidx = q.bidx + 3'h1;
                n.act = q.bidx != last;
            end
            if (q.pend && !fire) n.pcnt = q.pcnt - 3'h1;
            if (c_read) begin
                n.pend = 1'b1;
                n.pcnt = q.mode[`SFM_F_CL] - 3'h2;
                n.pcol = bus.a[7:0];
            end
            // program and erase timers
            if (prog_go && !busy && !vcc_low) begin
                n.busy_p = 1'b1;
                n.ptgt = ix;
                n.pdata = go_data;
                n.tcnt = 30'(PROG_CYC - 1);
            end
            if (erase_go && !busy && !vcc_low) begin
                n.busy_e = 1'b1;
                n.esec = go_row[12:10];
                n.tcnt = 30'(ERASE_CYC - 1);
            end
            if (ctm_go && !busy) n.ctm = 1'b1;
            if (busy) begin
                n.tcnt = q.tcnt - 30'h1;
                if (vcc_low) begin
                    n.busy_p = 1'b0;
                    n.busy_e = 1'b0;
                end else if (q.tcnt == 30'h0) begin
                    n.busy_p = 1'b0;
                    n.busy_e = 1'b0;
                    if (q.busy_p) n.mem[q.ptgt] = q.mem[q.ptgt] & q.pdata;
                    for (int j = 0; j < 8; j++) begin
                        if (q.busy_e) n.mem[{q.esec, 3'(j)}] = `SFM_ERASED;
                    end
                end
            end
        end
        if (q.ctm && (bus.a & `SFM_CTM_MASK) == `SFM_CTM_EXIT) n.ctm = 1'b0;
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            q <= '0;
            q.mem <= {64{`SFM_ERASED}};
            q.mode <= `SFM_MODE_RST;
            q.doe_n <= 1'b1;
        end else begin
            q <= n;
        end
    end

    // test mode pin pairs
    assign pin_map = {bus.vpp, bus.we_n, clk, bus.cke, bus.a[8], bus.a[6], bus.a[4], bus.a[3],
                      bus.a[2], bus.a[1], bus.a[0], bus.a[11], bus.word, bus.dqm, bus.ras_n,
                      bus.mode_register_strobe_n,
                      bus.vpp, bus.we_n, clk, bus.a[9], bus.a[7], bus.a[5], bus.a[4], bus.a[3],
                      bus.a[2], bus.a[1], bus.a[10], bus.a[12], bus.cs_n, bus.cas_n, bus.ras_n,
                      bus.mode_register_strobe_n};
    assign bus.d_dq = q.ctm ? pin_map : q.dout;
    assign bus.d_dq_oe_n = q.ctm ? {24'h000000, {8{bus.dqm}}} : {32{q.doe_n}};
endmodule // sfm_dev
`default_nettype wire

// [logic/sfm_ctl.sv]
// Purpose: memory controller end driven by software registers
// Assumes: register read data one cycle after the read strobe
// Notes: bus outputs registered, one cycle behind the state
`timescale 1ns/1ps
`default_nettype none
`include "sfm_params.svh"
module sfm_ctl (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic [7:0]  rg_addr,
    input  wire logic [31:0] rg_wdata,
    input  wire logic        rg_wr,
    input  wire logic        rg_rd,
    output logic [31:0]      rg_rdata,
    sfm_if.ctl               bus
);
    sfm_pkg::sfm_ctl_t q, n;
    logic [52:0] cyc;
    logic [2:0]  last;
    // row, column and data of each load cycle
    function automatic logic [52:0] seq_cyc(input sfm_pkg::sfm_op_t o, input logic [2:0] s,
                                            input logic [31:0] ad, input logic [31:0] d);
        unique case (s)
            3'h0: return {13'h0aa, 8'h55, 32'h0000_00aa};
            3'h1: return {13'h055, 8'h2a, 32'h0000_0055};
            3'h2: return {13'h0aa, 8'h55, o == sfm_pkg::OP_PROG ? 32'h0000_00a0 : 32'h0000_0080};
            3'h3: return o == sfm_pkg::OP_PROG ? {ad[28:16], ad[7:0], d}
                                               : {13'h0aa, 8'h55, 32'h0000_00aa};
            3'h4: return o == sfm_pkg::OP_ERASE ? {13'h055, 8'h2a, 32'h0000_0055}
                                                : {13'h0aa, 8'h55, 32'h0000_0070};
            default: return {ad[28:16], 8'h00, 24'h0, `SFM_ERASE_CODE};
        endcase
    endfunction
    assign cyc = seq_cyc(q.op, q.step, q.addr, q.data);
    assign last = q.op == sfm_pkg::OP_PROG ? 3'h3 : (q.op == sfm_pkg::OP_ERASE ? 3'h5 : 3'h4);

    always_comb begin
        n = q;
        n.cs_n = 1'b1;
        n.ras_n = 1'b1;
        n.cas_n = 1'b1;
        n.we_n = 1'b1;
        n.mr_n = 1'b1;
        n.dq_oe_n = 1'b1;
        n.dqm = q.st == sfm_pkg::ST_WAIT && q.op == sfm_pkg::OP_CTM_IN;
        if (rg_wr && rg_addr == `SFM_R_ADDR) n.addr = rg_wdata;
        if (rg_wr && rg_addr == `SFM_R_DATA) n.data = rg_wdata;
        n.rdata = 32'h0;
        if (rg_rd) begin
            unique case (rg_addr)
                `SFM_R_ADDR: n.rdata = q.addr;
                `SFM_R_DATA: n.rdata = q.data;
                `SFM_R_STAT: n.rdata = {30'h0, q.ctm, q.st != sfm_pkg::ST_IDLE};
                `SFM_R_MODE: n.rdata = {24'h0, q.mode};
                default: if (rg_addr[7:5] == 3'h1 && rg_addr[1:0] == 2'h0) n.rdata = q.rbuf[rg_addr[4:2]];
            endcase
        end
        unique case (q.st)
            sfm_pkg::ST_IDLE: begin
                if (rg_wr && rg_addr == `SFM_R_CTRL) begin
                    n.op = sfm_pkg::sfm_op_t'(rg_wdata[2:0]);
                    n.step = 3'h0;
                    unique case (n.op)
                        sfm_pkg::OP_MODE: n.st = q.ctm ? sfm_pkg::ST_IDLE : sfm_pkg::ST_CMD;
                        sfm_pkg::OP_CTM_OUT: begin
                            n.st = sfm_pkg::ST_WAIT;
                            n.cnt = 11'(`SFM_CTM_CYC);
                        end
                        sfm_pkg::OP_NONE: n.st = sfm_pkg::ST_IDLE;
                        default: n.st = (q.ctm || n.op == 3'h7) ? sfm_pkg::ST_IDLE
                                                                 : sfm_pkg::ST_ACT;
                    endcase
                end
            end
            sfm_pkg::ST_ACT: begin
                n.cs_n = 1'b0;
                n.ras_n = 1'b0;
                n.ba = q.op == sfm_pkg::OP_READ ? q.addr[28:16] : cyc[52:40];
                n.st = q.mode[`SFM_F_RL] ? sfm_pkg::ST_GAP : sfm_pkg::ST_CMD;
            end
            sfm_pkg::ST_GAP: n.st = sfm_pkg::ST_CMD;
            sfm_pkg::ST_CMD: begin
                n.cs_n = 1'b0;
                n.cas_n = 1'b0;
                n.st = sfm_pkg::ST_WAIT;
                if (q.op == sfm_pkg::OP_MODE) begin
                    n.ras_n = 1'b0;
                    n.mr_n = 1'b0;
                    n.ba = {5'h00, q.data[7:0]};
                    n.mode = sfm_pkg::mode_merge(q.mode, q.data[7:0]);
                    n.cnt = `SFM_MRS_WAIT;
                end else if (q.op == sfm_pkg::OP_READ) begin
                    n.ba = {5'h00, q.addr[7:0]};
                    n.ridx = 3'h0;
                    n.cnt = {8'h00, q.mode[`SFM_F_CL]} + 11'h00a;
                end else begin
                    n.we_n = 1'b0;
                    n.ba = {5'h00, cyc[39:32]};
                    n.dq = cyc[31:0];
                    n.dq_oe_n = 1'b0;
                    n.step = q.step + 3'h1;
                    n.cnt = 11'(`SFM_CTM_CYC);
                    n.ctm = q.op == sfm_pkg::OP_CTM_IN;
                    if (q.step != last) begin
                        n.st = sfm_pkg::ST_ACT;
                        n.ctm = 1'b0;
                    end
                    if (q.op != sfm_pkg::OP_CTM_IN) n.cnt = 11'h000;
                end
            end
            sfm_pkg::ST_WAIT: begin
                if (q.op == sfm_pkg::OP_READ && !bus.d_dq_oe_n[0]) begin
                    n.rbuf[q.ridx] = bus.dq;
                    n.ridx = q.ridx + 3'h1;
                end
                if (q.op == sfm_pkg::OP_CTM_OUT) n.ba = `SFM_CTM_EXIT;
                n.cnt = q.cnt - 11'h001;
                if (q.cnt == 11'h000) begin
                    n.st = sfm_pkg::ST_IDLE;
                    if (q.op == sfm_pkg::OP_CTM_OUT) n.ctm = 1'b0;
                end
            end
            default: n.st = sfm_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            q <= '0;
            q.mode <= `SFM_MODE_RST;
            {q.cs_n, q.ras_n, q.cas_n, q.we_n, q.mr_n, q.dqm, q.dq_oe_n} <= 7'h7f;
        end else begin
            q <= n;
        end
    end

    assign rg_rdata = q.rdata;
    assign bus.cke = 1'b1;
    assign bus.word = 1'b1;
    assign bus.vpp = 1'b0;
    assign bus.cs_n = q.cs_n;
    assign bus.ras_n = q.ras_n;
    assign bus.cas_n = q.cas_n;
    assign bus.we_n = q.we_n;
    assign bus.mode_register_strobe_n = q.mr_n;
    assign bus.dqm = q.dqm;
    assign bus.a = q.ba;
    assign bus.c_dq = q.dq;
    assign bus.c_dq_oe_n = {32{q.dq_oe_n}};
endmodule // sfm_ctl
`default_nettype wire

// [testbench/sfm_link_props.sv]
// Purpose: link checks between controller end and flash end
// Assumes: one clock, resetn synchronous active low
// Notes: mode fields tracked from mode writes on the link
`timescale 1ns/1ps
`default_nettype none
module sfm_link_props (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic        cke,
    input wire logic        cs_n,
    input wire logic        ras_n,
    input wire logic        cas_n,
    input wire logic        we_n,
    input wire logic        mode_register_strobe_n,
    input wire logic        dqm,
    input wire logic [12:0] a,
    input wire logic [31:0] d_dq,
    input wire logic [31:0] d_dq_oe_n
);
    logic [2:0]  cl;
    logic [4:0]  bl;
    logic        rl2;
    logic        row_ok;
    logic        tm;
    logic [15:0] rd_sh;
    wire logic sel = cke && !cs_n;
    wire logic mrw = sel && !ras_n && !cas_n && !mode_register_strobe_n;
    wire logic act = sel && !ras_n && cas_n && mode_register_strobe_n;
    wire logic rd = sel && ras_n && !cas_n && mode_register_strobe_n && we_n;
    wire logic tsig = d_dq_oe_n[0] && !d_dq_oe_n[8];
    wire logic win = |((rd_sh >> (cl - 3'h1)) & ((16'h1 << bl) - 16'h1));
    always_ff @(posedge clk) begin
        if (!resetn) begin
            cl <= 3'h5;
            bl <= 5'h4;
            rl2 <= 1'b1;
            row_ok <= 1'b0;
            tm <= 1'b0;
            rd_sh <= 16'h0;
        end else begin
            rd_sh <= {rd_sh[14:0], rd};
            row_ok <= row_ok || act;
            tm <= tsig || (tm && ((a & 13'h1c07) != 13'h0805));
            if (mrw && !tm && a[5:3] >= 3'h2 && a[5:3] <= 3'h6) cl <= a[5:3];
            if (mrw && !tm && a[1]) bl <= a[0] ? 5'h8 : 5'h4;
            if (mrw && !tm) rl2 <= a[6];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence s_mode_wr;
        mrw;
    endsequence
    sequence s_quiet;
        (cs_n || (ras_n && cas_n && mode_register_strobe_n))[*3];
    endsequence
    chk_mode_quiet: assert property (s_mode_wr |=> s_quiet)
        else $error("command too soon after mode write");
    chk_first_word: assert property (rd_sh[cl - 3'h1] && !$past(dqm, 3) && !tm
        |-> !d_dq_oe_n[0]) else $error("first burst word missing");
    chk_bus_float: assert property (!win && !tm && !tsig |-> d_dq_oe_n == 32'hffffffff)
        else $error("data driven outside a burst");
    chk_mask_two: assert property (dqm && !tm |-> ##3 (d_dq_oe_n[0] || tm))
        else $error("masked word driven");
    chk_pin_follow: assert property (tm |-> d_dq[0] == mode_register_strobe_n
        && d_dq[16] == mode_register_strobe_n && d_dq[1] == ras_n && d_dq[3] == cs_n
        && d_dq[14] == we_n && d_dq[7] == a[2] && d_dq[18] == dqm)
        else $error("test pin not following");
    chk_read_row: assert property (rd |-> row_ok)
        else $error("read without open row");
    chk_ras_gap: assert property (act && rl2 |=> !rd)
        else $error("read too soon after row active");
    chk_clock_on: assert property (cke)
        else $error("clock enable low");
endmodule // sfm_link_props
`default_nettype wire

// [testbench/tb_sync_flash_mode_and_program_control.sv]
// Purpose: drives controller registers and checks flash results
// Assumes: short program and erase counts
// Notes: expected words worked out from the commands issued
`timescale 1ns/1ps
`default_nettype none
`include "sfm_params.svh"
module tb_sync_flash_mode_and_program_control;
    localparam int unsigned PC = 300;
    localparam int unsigned EC = 600;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic        vcc_low = 1'b0;
    logic [7:0]  rg_addr = 8'h00;
    logic [31:0] rg_wdata = 32'h0;
    logic        rg_wr = 1'b0;
    logic        rg_rd = 1'b0;
    logic [31:0] rg_rdata;
    logic [31:0] v;
    int          fail_count = 0;
    int          compares = 0;
    sfm_if sfm_if_i ();
    sfm_dev #(.PROG_CYC(PC), .ERASE_CYC(EC)) sfm_dev_i (.clk(clk), .resetn(resetn),
        .vcc_low(vcc_low), .bus(sfm_if_i.dev));
    sfm_ctl sfm_ctl_i (.clk(clk), .resetn(resetn), .rg_addr(rg_addr), .rg_wdata(rg_wdata),
        .rg_wr(rg_wr), .rg_rd(rg_rd), .rg_rdata(rg_rdata), .bus(sfm_if_i.ctl));
    sfm_link_props sfm_link_props_i (.clk(clk), .resetn(resetn), .cke(sfm_if_i.cke),
        .cs_n(sfm_if_i.cs_n), .ras_n(sfm_if_i.ras_n), .cas_n(sfm_if_i.cas_n),
        .we_n(sfm_if_i.we_n), .mode_register_strobe_n(sfm_if_i.mode_register_strobe_n),
        .dqm(sfm_if_i.dqm), .a(sfm_if_i.a), .d_dq(sfm_if_i.d_dq),
        .d_dq_oe_n(sfm_if_i.d_dq_oe_n));
    initial begin
        forever #2 clk = ~clk;
    end
    task automatic final_report();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        @(posedge clk);
        rg_addr <= ad;
        rg_wdata <= d;
        rg_wr <= 1'b1;
        @(posedge clk);
        rg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] ad);
        @(posedge clk);
        rg_addr <= ad;
        rg_rd <= 1'b1;
        @(posedge clk);
        rg_rd <= 1'b0;
        #1 v = rg_rdata;
    endtask
    task automatic op(input logic [31:0] ad, input logic [31:0] d, input logic [2:0] c);
        int n;
        wr(`SFM_R_ADDR, ad);
        wr(`SFM_R_DATA, d);
        wr(`SFM_R_CTRL, {29'h0, c});
        n = 0;
        v = 32'h1;
        while (v[0] !== 1'b0 && n < 3000) begin
            rd(`SFM_R_STAT);
            n++;
        end
        if (n >= 3000) begin
            fail_count++;
            final_report();
        end
    endtask
    task automatic word0(input logic [31:0] ad, input logic [31:0] e);
        op(ad, 32'h0, 3'h2);
        rd(`SFM_R_BUF);
        chk("first word", e, v);
    endtask
    task automatic burst(input logic [31:0] ad, input int bl, input logic il,
                         input logic [31:0] base);
        logic [2:0] s;
        logic [2:0] m;
        logic [2:0] i;
        s = ad[2:0];
        m = 3'(bl - 1);
        op(ad, 32'h0, 3'h2);
        for (int k = 0; k < bl; k++) begin
            i = il ? (s ^ 3'(k)) : ((s & ~m) | ((s + 3'(k)) & m));
            rd(8'(`SFM_R_BUF + 4 * k));
            chk("burst word", base | {29'h0, i}, v);
        end
    endtask
    initial begin
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        rd(`SFM_R_MODE);
        chk("mode", 32'h6a, v);
        rd(8'h40);
        chk("unmapped", 32'h0, v);
        burst(32'h0000_0001, 4, 1'b0, 32'hffffffff);
        for (int c = 0; c < 8; c++) begin
            op(32'h0800_0000 | c, 32'h5a5a_0000 | c, 3'h3);
            repeat (PC + 10) @(posedge clk);
        end
        op(32'h0400_0000, 32'h1234_5688, 3'h3);
        op(32'h0400_0000, 32'h0, 3'h2);
        rd(`SFM_R_BUF);
        chk("poll bit", 32'h0, {31'h0, v[7]});
        repeat (PC + 10) @(posedge clk);
        word0(32'h0400_0000, 32'h1234_5688);
        op(32'h0400_0000, 32'hffff_0000, 3'h3);
        repeat (PC + 10) @(posedge clk);
        word0(32'h0400_0000, 32'h1234_0000);
        op(32'h0000_0001, 32'h0, 3'h3);
        repeat (PC + 10) @(posedge clk);
        op(32'h0100_0003, 32'h0, 3'h4);
        op(32'h0000_0002, 32'h0, 3'h3);
        op(32'h0000_0001, 32'h0, 3'h2);
        rd(`SFM_R_BUF);
        chk("erase poll", 32'h0, {31'h0, v[7]});
        repeat (EC + 10) @(posedge clk);
        burst(32'h0000_0001, 4, 1'b0, 32'hffffffff);
        word0(32'h0400_0000, 32'h1234_0000);
        op(32'h0, 32'h1b, 3'h1);
        rd(`SFM_R_MODE);
        chk("mode", 32'h1b, v);
        burst(32'h0800_0005, 8, 1'b0, 32'h5a5a_0000);
        op(32'h0, 32'h3f, 3'h1);
        rd(`SFM_R_MODE);
        chk("mode", 32'h1f, v);
        burst(32'h0800_0005, 8, 1'b1, 32'h5a5a_0000);
        @(posedge clk) vcc_low <= 1'b1;
        op(32'h0000_0003, 32'h0, 3'h3);
        repeat (PC + 10) @(posedge clk);
        vcc_low <= 1'b0;
        op(32'h0000_0004, 32'h0, 3'h3);
        repeat (20) @(posedge clk);
        vcc_low <= 1'b1;
        repeat (5) @(posedge clk);
        vcc_low <= 1'b0;
        repeat (PC + 10) @(posedge clk);
        burst(32'h0000_0000, 8, 1'b1, 32'hffffffff);
        op(32'h0, 32'h0, 3'h5);
        rd(`SFM_R_STAT);
        chk("test mode", 32'h1, {31'h0, v[1]});
        op(32'h0, 32'h0, 3'h6);
        rd(`SFM_R_STAT);
        chk("test mode", 32'h0, {31'h0, v[1]});
        final_report();
    end
endmodule // tb_sync_flash_mode_and_program_control
`default_nettype wire
